/* File: inc/irq_front_pkg.sv */
package irq_front_pkg;

	// Source counts and field widths.
	localparam int N_PIN = 8;
	localparam int N_PER = 8;
	localparam int N_SRC = N_PIN + N_PER;
	localparam int LVL_W = 3;
	localparam int ID_W = 4;
	localparam int N_EV = 3;
	localparam int ADDR_W = 8;

	// Register byte addresses.
	localparam logic [ADDR_W-1:0] ADDR_SYSCTL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_SENSE = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_PRI_EXT = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_PRI_PER = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_PER_EN = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_DMA_RT = 8'h1c;
	localparam logic [ADDR_W-1:0] ADDR_DTE_RT = 8'h20;
	localparam logic [ADDR_W-1:0] ADDR_EV_STAT = 8'h24;
	localparam logic [ADDR_W-1:0] ADDR_EV_MASK = 8'h28;
	localparam logic [ADDR_W-1:0] ADDR_PER_FLAG = 8'h2c;

	// Field positions.
	localparam int NMI_EDGE_POS = 0;
	localparam int EV_NMI = 0;
	localparam int EV_WAKE = 1;
	localparam int EV_PIN = 2;

	// Reset values.
	localparam logic RST_NMI_EDGE = 1'b0;
	localparam logic [2*N_PIN-1:0] RST_SENSE = 16'h0000;
	localparam logic [N_PIN-1:0] RST_PIN_BITS = 8'h00;
	localparam logic [N_PER-1:0] RST_PER_BITS = 8'h00;
	localparam logic [LVL_W*N_PIN-1:0] RST_PRI = 24'h000000;
	localparam logic [N_EV-1:0] RST_EV = 3'h0;

	// Sense codes: bit b is the high bit, bit a the low bit.
	localparam logic [1:0] SENSE_LOW = 2'h0;
	localparam logic [1:0] SENSE_FALL = 2'h1;
	localparam logic [1:0] SENSE_RISE = 2'h2;
	localparam logic [1:0] SENSE_BOTH = 2'h3;

	// Request handed to the CPU side.
	typedef struct packed {
		logic valid;
		logic [ID_W-1:0] id;
		logic [LVL_W-1:0] level;
	} arb_t;

endpackage : irq_front_pkg

/* File: hw/irq_pin_detect.sv */
`timescale 1ns/1ns
module irq_pin_detect (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin_level,
	input wire logic [1:0] sense,
	output logic hit
);
	import irq_front_pkg::*;

	logic sync1_reg;
	logic sync2_reg;
	logic prev_reg;
	logic [2:0] fill_reg;
	logic hit_c;

	// Two-stage synchroniser, then one history stage for edges.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			prev_reg <= 1'b1;
			fill_reg <= 3'h0;
		end else begin
			sync1_reg <= pin_level; // RULE_17
			sync2_reg <= sync1_reg; // RULE_17
			prev_reg <= sync2_reg;
			fill_reg <= {fill_reg[1:0], 1'b1};
		end
	end

	wire armed = fill_reg[2];
	wire fall = prev_reg & ~sync2_reg;
	wire rise = ~prev_reg & sync2_reg;

	always_comb begin
		case (sense) // RULE_06
			SENSE_LOW: hit_c = ~sync2_reg;
			SENSE_FALL: hit_c = fall;
			SENSE_RISE: hit_c = rise;
			default: hit_c = fall | rise;
		endcase
	end

	// Reset-time history is not real, so detection waits until it is.
	assign hit = armed & hit_c;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_rise_latency;
		(sense == SENSE_RISE) && hit |-> $past(pin_level, 2) && !$past(pin_level, 3);
	endproperty
	a_rise_latency: assert property (p_rise_latency) // RULE_17
		else $error("rising hit without a rising pin two cycles earlier");

	property p_fall_once;
		(sense == SENSE_FALL) && hit |=> !hit;
	endproperty
	a_fall_once: assert property (p_fall_once) // RULE_17
		else $error("one falling edge reported twice");

	property p_low_level;
		armed && $stable(sense) && (sense == SENSE_LOW) && !$past(pin_level, 2) |-> hit;
	endproperty
	a_low_level: assert property (p_low_level) // RULE_06
		else $error("low level not detected");

endmodule : irq_pin_detect

/* File: hw/irq_front_end.sv */
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
// Overview of operation
// RULE_01 - NMI plus request pins, all wake capable.
// RULE_02 - External request restores device from standby.
// RULE_03 - Pin 6 serves USB, same detection.
// RULE_04 - NMI highest, always passed to CPU.
// RULE_05 - Control bit picks NMI rising or falling.
// RULE_06 - Per-pin sense: low, fall, rise, both.
// RULE_07 - Enable bit gates each pin request.
// RULE_08 - Priority field sets pin arbitration level.
// RULE_09 - Pending flags shown, cleared by writing zero.
// RULE_10 - Detection independent of pin direction.
// RULE_11 - Pending set even when pin disabled.
// RULE_12 - Peripheral request needs flag and enable.
// RULE_13 - Peripheral sources get priority levels too.
// RULE_14 - Peripheral requests can trigger DMA engines.
// RULE_15 - Engine activation ignores CPU mask state.
// RULE_16 - Equal priority: lower number wins.
// RULE_17 - Synchronise pins; each event sets once.
module irq_front_end (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [irq_front_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic nmi_pin,
	input wire logic [irq_front_pkg::N_PIN-1:0] irq_pin_n,
	input wire logic [irq_front_pkg::N_PER-1:0] per_flag,
	input wire logic standby,
	output logic nmi_req,
	output irq_front_pkg::arb_t cpu_req,
	output logic wake,
	output logic [irq_front_pkg::N_PER-1:0] dma_act,
	output logic [irq_front_pkg::N_PER-1:0] dte_act,
	output logic irq
);
	import irq_front_pkg::*;

	////////////////////////////////////////////////////////////////
	// State.

	logic nmi_edge_reg;
	logic [2*N_PIN-1:0] sense_reg;
	logic [N_PIN-1:0] ien_reg;
	logic [N_PIN-1:0] pending_reg;
	logic [N_PIN-1:0] pending_next;
	logic [LVL_W*N_PIN-1:0] pri_ext_reg;
	logic [LVL_W*N_PER-1:0] pri_per_reg;
	logic [N_PER-1:0] pen_reg;
	logic [N_PER-1:0] dma_rt_reg;
	logic [N_PER-1:0] dte_rt_reg;
	logic [N_EV-1:0] ev_reg;
	logic [N_EV-1:0] ev_next;
	logic [N_EV-1:0] ev_mask_reg;
	logic [31:0] rd_mux;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic nmi_req_reg;
	arb_t cpu_req_reg;
	logic wake_reg;
	logic [N_PER-1:0] dma_act_reg;
	logic [N_PER-1:0] dte_act_reg;
	logic irq_reg;
	logic nmi_hit;
	logic [N_PIN-1:0] pin_hit;

	////////////////////////////////////////////////////////////////
	// Pin detection.

	// The pad level is sampled whatever the pin's direction.
	irq_pin_detect u_nmi_detect (
		.pclk(pclk),
		.presetn(presetn),
		.pin_level(nmi_pin), // RULE_10
		.sense(nmi_edge_reg ? SENSE_RISE : SENSE_FALL), // RULE_05
		.hit(nmi_hit)
	);

	// Line 6 carries the USB function's request into the same detector.
	genvar gi;
	generate
		for (gi = 0; gi < N_PIN; gi++) begin : g_pin // RULE_03
			irq_pin_detect u_detect (
				.pclk(pclk),
				.presetn(presetn),
				.pin_level(irq_pin_n[gi]), // RULE_10
				.sense(sense_reg[2*gi +: 2]), // RULE_06
				.hit(pin_hit[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// APB decode.

	wire setup = psel & ~penable;
	wire wr_en = psel & penable & pready_reg & pwrite;

	wire sel_sysctl = paddr == ADDR_SYSCTL;
	wire sel_sense = paddr == ADDR_SENSE;
	wire sel_ien = paddr == ADDR_IRQ_EN;
	wire sel_stat = paddr == ADDR_IRQ_STAT;
	wire sel_pri_ext = paddr == ADDR_PRI_EXT;
	wire sel_pri_per = paddr == ADDR_PRI_PER;
	wire sel_pen = paddr == ADDR_PER_EN;
	wire sel_dma = paddr == ADDR_DMA_RT;
	wire sel_dte = paddr == ADDR_DTE_RT;
	wire sel_ev = paddr == ADDR_EV_STAT;
	wire sel_mask = paddr == ADDR_EV_MASK;
	wire sel_flag = paddr == ADDR_PER_FLAG;

	wire addr_ok = sel_sysctl | sel_sense | sel_ien | sel_stat |
		sel_pri_ext | sel_pri_per | sel_pen | sel_dma | sel_dte |
		sel_ev | sel_mask | sel_flag;

	wire wr_stat = wr_en & sel_stat;
	wire wr_ev = wr_en & sel_ev;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_sysctl) begin
			rd_mux[NMI_EDGE_POS] = nmi_edge_reg;
		end else if (sel_sense) begin
			rd_mux[2*N_PIN-1:0] = sense_reg;
		end else if (sel_ien) begin
			rd_mux[N_PIN-1:0] = ien_reg;
		end else if (sel_stat) begin
			rd_mux[N_PIN-1:0] = pending_reg; // RULE_09
		end else if (sel_pri_ext) begin
			rd_mux[LVL_W*N_PIN-1:0] = pri_ext_reg;
		end else if (sel_pri_per) begin
			rd_mux[LVL_W*N_PER-1:0] = pri_per_reg;
		end else if (sel_pen) begin
			rd_mux[N_PER-1:0] = pen_reg;
		end else if (sel_dma) begin
			rd_mux[N_PER-1:0] = dma_rt_reg;
		end else if (sel_dte) begin
			rd_mux[N_PER-1:0] = dte_rt_reg;
		end else if (sel_ev) begin
			rd_mux[N_EV-1:0] = ev_reg;
		end else if (sel_mask) begin
			rd_mux[N_EV-1:0] = ev_mask_reg;
		end else if (sel_flag) begin
			rd_mux[N_PER-1:0] = per_flag;
		end
	end

	// Every transfer completes with no wait state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= setup;
			pslverr_reg <= setup & ~addr_ok;
			prdata_reg <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////
	// Configuration registers.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_edge_reg <= RST_NMI_EDGE;
			sense_reg <= RST_SENSE;
			ien_reg <= RST_PIN_BITS;
			pri_ext_reg <= RST_PRI;
			pri_per_reg <= RST_PRI;
			pen_reg <= RST_PER_BITS;
			dma_rt_reg <= RST_PER_BITS;
			dte_rt_reg <= RST_PER_BITS;
			ev_mask_reg <= RST_EV;
		end else if (wr_en) begin
			if (sel_sysctl) begin
				nmi_edge_reg <= pwdata[NMI_EDGE_POS]; // RULE_05
			end
			if (sel_sense) begin
				sense_reg <= pwdata[2*N_PIN-1:0]; // RULE_06
			end
			if (sel_ien) begin
				ien_reg <= pwdata[N_PIN-1:0]; // RULE_07
			end
			if (sel_pri_ext) begin
				pri_ext_reg <= pwdata[LVL_W*N_PIN-1:0]; // RULE_08
			end
			if (sel_pri_per) begin
				pri_per_reg <= pwdata[LVL_W*N_PER-1:0]; // RULE_13
			end
			if (sel_pen) begin
				pen_reg <= pwdata[N_PER-1:0]; // RULE_12
			end
			if (sel_dma) begin
				dma_rt_reg <= pwdata[N_PER-1:0]; // RULE_14
			end
			if (sel_dte) begin
				dte_rt_reg <= pwdata[N_PER-1:0]; // RULE_14
			end
			if (sel_mask) begin
				ev_mask_reg <= pwdata[N_EV-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Pending flags and events.

	// A new detection in the clearing cycle survives the clear.
	wire [N_PIN-1:0] stat_clr = wr_stat ? ~pwdata[N_PIN-1:0] : RST_PIN_BITS;
	assign pending_next = (pending_reg & ~stat_clr) | pin_hit; // RULE_09 RULE_11

	wire wake_ev = standby & (nmi_hit | (|(pin_hit & ien_reg))); // RULE_01 RULE_02
	wire [N_EV-1:0] ev_set = {|pin_hit, wake_ev, nmi_hit};
	wire [N_EV-1:0] ev_clr = wr_ev ? pwdata[N_EV-1:0] : RST_EV;
	assign ev_next = (ev_reg & ~ev_clr) | ev_set;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_reg <= RST_PIN_BITS;
			ev_reg <= RST_EV;
		end else begin
			pending_reg <= pending_next;
			ev_reg <= ev_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Arbitration.

	wire [N_SRC-1:0] req_vec = {per_flag & pen_reg, pending_reg & ien_reg}; // RULE_07 RULE_12
	wire [LVL_W*N_SRC-1:0] lvl_vec = {pri_per_reg, pri_ext_reg};

	// Strict compare keeps the lowest-numbered source on a tie.
	function automatic arb_t arbitrate(
		input logic [N_SRC-1:0] req,
		input logic [LVL_W*N_SRC-1:0] lvl
	);
		arb_t best;
		best = '0;
		for (int i = 0; i < N_SRC; i++) begin
			if (req[i] && (!best.valid || lvl[LVL_W*i +: LVL_W] > best.level)) begin
				best.valid = 1'b1;
				best.id = ID_W'(i);
				best.level = lvl[LVL_W*i +: LVL_W];
			end
		end
		return best;
	endfunction : arbitrate

	wire arb_t arb_win = arbitrate(req_vec, lvl_vec); // RULE_08 RULE_13 RULE_16

	////////////////////////////////////////////////////////////////
	// Outputs.

	// Engine triggers bypass ev_mask_reg but still need the same pen_reg enable as the CPU request.
	wire [N_PER-1:0] per_req = per_flag & pen_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_req_reg <= 1'b0;
			cpu_req_reg <= '0;
			wake_reg <= 1'b0;
			dma_act_reg <= RST_PER_BITS;
			dte_act_reg <= RST_PER_BITS;
			irq_reg <= 1'b0;
		end else begin
			nmi_req_reg <= nmi_hit; // RULE_04
			cpu_req_reg <= arb_win;
			wake_reg <= wake_ev; // RULE_02
			dma_act_reg <= per_req & dma_rt_reg; // RULE_14 RULE_15
			dte_act_reg <= per_req & dte_rt_reg; // RULE_14 RULE_15
			irq_reg <= |(ev_next & ev_mask_reg);
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign nmi_req = nmi_req_reg;
	assign cpu_req = cpu_req_reg;
	assign wake = wake_reg;
	assign dma_act = dma_act_reg;
	assign dte_act = dte_act_reg;
	assign irq = irq_reg;

	////////////////////////////////////////////////////////////////
	// Checks.

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_nmi_pass;
		nmi_hit |=> nmi_req ##1 !nmi_req;
	endproperty
	a_nmi_pass: assert property (p_nmi_pass) // RULE_04
		else $error("NMI detection not passed as one pulse");

	property p_set_disabled;
		pin_hit != 8'h00 |=> (pending_reg & $past(pin_hit)) == $past(pin_hit);
	endproperty
	a_set_disabled: assert property (p_set_disabled) // RULE_11
		else $error("detected pin did not set its pending flag");

	property p_clear_zero;
		wr_stat && !pwdata[0] && !pin_hit[0] |=> !pending_reg[0];
	endproperty
	a_clear_zero: assert property (p_clear_zero) // RULE_09
		else $error("writing zero did not clear pending flag 0");

	property p_keep_one;
		wr_stat && pwdata[0] && pending_reg[0] |=> pending_reg[0];
	endproperty
	a_keep_one: assert property (p_keep_one) // RULE_09
		else $error("writing one changed pending flag 0");

	property p_gate;
		cpu_req.valid |-> $past(|req_vec);
	endproperty
	a_gate: assert property (p_gate) // RULE_07
		else $error("CPU request without an enabled source");

	property p_engine;
		##1 dma_act == $past(per_flag & pen_reg & dma_rt_reg);
	endproperty
	a_engine: assert property (p_engine) // RULE_15
		else $error("DMA trigger not flag, enable and route");

	property p_wake;
		standby && nmi_hit |=> wake && ev_reg[EV_WAKE];
	endproperty
	a_wake: assert property (p_wake) // RULE_02
		else $error("NMI in standby did not wake");

	property p_tie;
		req_vec[0] && lvl_vec[LVL_W-1:0] == 3'h7 |=> cpu_req.id == 4'h0;
	endproperty
	a_tie: assert property (p_tie) // RULE_16
		else $error("source 0 at top level lost arbitration");

	c_nmi: cover property (nmi_hit ##1 nmi_req);
	c_clear: cover property (wr_stat && pending_reg != 8'h00);
	c_wake: cover property (standby && wake_ev);
	c_dte: cover property (dte_act != 8'h00);

endmodule : irq_front_end

/* File: verif/ext_pins.sv */
`timescale 1ns/1ns
module ext_pins (
	input wire logic pclk,
	output logic nmi_pin,
	output logic [irq_front_pkg::N_PIN-1:0] irq_pin_n
);
	import irq_front_pkg::*;

	// Request pads rest high, as a pulled-up line does when no device pulls it low.
	initial begin
		nmi_pin = 1'b0;
		irq_pin_n = '1;
	end

	// A device may answer promptly or only after some cycles of lag.
	task automatic drive(input int n, input logic v, input int lag);
		repeat (lag) @(posedge pclk);
		irq_pin_n[n] <= v;
	endtask : drive

	task automatic drive_nmi(input logic v);
		nmi_pin <= v;
	endtask : drive_nmi
endmodule : ext_pins

/* File: verif/interrupt_source_front_end_tb.sv */
`timescale 1ns/1ns
module interrupt_source_front_end_tb;
	import irq_front_pkg::*;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, seed;
	logic nmi_pin, standby, nmi_req, wake, irq;
	logic [N_PIN-1:0] irq_pin_n;
	logic [N_PER-1:0] per_flag, dma_act, dte_act;
	arb_t cpu_req;
	logic [32:0] exp_q[$];
	logic [32:0] bitv;
	int err_total, samples_checked, nmi_cnt, wake_cnt, i;

	irq_front_end u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nmi_pin(nmi_pin), .irq_pin_n(irq_pin_n), .per_flag(per_flag),
		.standby(standby), .nmi_req(nmi_req), .cpu_req(cpu_req), .wake(wake),
		.dma_act(dma_act), .dte_act(dte_act), .irq(irq));
	ext_pins u_ext (.pclk(pclk), .nmi_pin(nmi_pin), .irq_pin_n(irq_pin_n));

	always #2 pclk = ~pclk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask : cmp

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	// The expected answer {pslverr, prdata} is queued before the request goes out.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		exp_q.push_back(e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1)
			cmp("apb answer", exp_q.pop_front(), {pslverr, prdata});
		if (nmi_req === 1'b1)
			nmi_cnt++;
		if (wake === 1'b1)
			wake_cnt++;
	end

	initial begin
		repeat (5000) @(posedge pclk);
		err_total++;
		conclude();
	end

	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		per_flag = 0; standby = 0; seed = 32'h0e49; err_total = 0; samples_checked = 0;
		nmi_cnt = 0;
		wake_cnt = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		for (i = 0; i <= 'h2c; i += 4)
			apb(1'b0, 8'(i), 32'h0, 33'h0);
		apb(1'b0, 8'h30, 32'h0, {1'b1, 32'h0});
		apb(1'b1, 8'h30, 32'hffff_ffff, {1'b1, 32'h0});
		////////////////////////////////////////////////////////////////////////////////
		for (i = 0; i < N_PIN; i++) begin
			bitv = 33'h1 << i;
			apb(1'b1, ADDR_SENSE, 32'(i % 4) << (2 * i), 33'h0);
			apb(1'b1, ADDR_IRQ_STAT, 32'h0, 33'h0);
			u_ext.drive(i, 1'b0, int'(seed[1:0]));
			seed = lfsr(seed);
			repeat (5) @(posedge pclk);
			apb(1'b0, ADDR_IRQ_STAT, 32'h0, (i % 4 == 2) ? 33'h0 : bitv);
			apb(1'b1, ADDR_IRQ_STAT, 32'h0, 33'h0);
			u_ext.drive(i, 1'b1, 0);
			repeat (5) @(posedge pclk);
			apb(1'b0, ADDR_IRQ_STAT, 32'h0, (i % 4 == 1) ? 33'h0 : bitv);
			apb(1'b1, ADDR_IRQ_STAT, ~bitv[31:0], 33'h0);
			apb(1'b0, ADDR_IRQ_STAT, 32'h0, 33'h0);
		end
		////////////////////////////////////////////////////////////////////////////////
		apb(1'b1, ADDR_SENSE, 32'h44, 33'h0);
		apb(1'b1, ADDR_PRI_EXT, 32'h0a10, 33'h0);
		apb(1'b1, ADDR_IRQ_EN, 32'h0a, 33'h0);
		apb(1'b1, ADDR_EV_MASK, 32'h6, 33'h0);
		u_ext.drive(1, 1'b0, 0);
		u_ext.drive(3, 1'b0, 0);
		repeat (6) @(posedge pclk);
		cmp("cpu_req", 33'({1'b1, 4'd3, 3'd5}), 33'(cpu_req));
		apb(1'b1, ADDR_PRI_EXT, 32'h0410, 33'h0);
		// The winner register follows a configuration write one edge after it lands.
		@(posedge pclk);
		cmp("cpu_req", 33'({1'b1, 4'd1, 3'd2}), 33'(cpu_req));
		apb(1'b1, ADDR_IRQ_EN, 32'h08, 33'h0);
		@(posedge pclk);
		cmp("cpu_req", 33'({1'b1, 4'd3, 3'd2}), 33'(cpu_req));
		cmp("irq", 33'h1, 33'(irq));
		apb(1'b1, ADDR_EV_STAT, 32'h7, 33'h0);
		cmp("irq", 33'h0, 33'(irq));
		standby <= 1'b1;
		u_ext.drive(1, 1'b1, 0);
		u_ext.drive(3, 1'b1, 0);
		repeat (4) @(posedge pclk);
		u_ext.drive(1, 1'b0, 0);
		repeat (6) @(posedge pclk);
		apb(1'b0, ADDR_EV_STAT, 32'h0, 33'h4);
		cmp("wake count", 33'h0, 33'(wake_cnt));
		u_ext.drive(3, 1'b0, 0);
		repeat (6) @(posedge pclk);
		apb(1'b0, ADDR_EV_STAT, 32'h0, 33'h6);
		cmp("wake count", 33'h1, 33'(wake_cnt));
		standby <= 1'b0;
		apb(1'b1, ADDR_EV_STAT, 32'h7, 33'h0);
		////////////////////////////////////////////////////////////////////////////////
		apb(1'b1, ADDR_EV_MASK, 32'h0, 33'h0);
		apb(1'b1, ADDR_SYSCTL, 32'h1, 33'h0);
		u_ext.drive_nmi(1'b1);
		repeat (6) @(posedge pclk);
		cmp("nmi count", 33'h1, 33'(nmi_cnt));
		cmp("irq", 33'h0, 33'(irq));
		apb(1'b0, ADDR_EV_STAT, 32'h0, 33'h1);
		apb(1'b1, ADDR_EV_MASK, 32'h1, 33'h0);
		// The interrupt line sees a new mask one edge after the write lands.
		@(posedge pclk);
		cmp("irq", 33'h1, 33'(irq));
		u_ext.drive_nmi(1'b0);
		repeat (6) @(posedge pclk);
		cmp("nmi count", 33'h1, 33'(nmi_cnt));
		apb(1'b1, ADDR_SYSCTL, 32'h0, 33'h0);
		u_ext.drive_nmi(1'b1);
		repeat (6) @(posedge pclk);
		cmp("nmi count", 33'h1, 33'(nmi_cnt));
		standby <= 1'b1;
		u_ext.drive_nmi(1'b0);
		repeat (6) @(posedge pclk);
		cmp("nmi count", 33'h2, 33'(nmi_cnt));
		cmp("wake count", 33'h2, 33'(wake_cnt));
		standby <= 1'b0;
		apb(1'b1, ADDR_EV_STAT, 32'h1, 33'h0);
		cmp("irq", 33'h0, 33'(irq));
		////////////////////////////////////////////////////////////////////////////////
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			per_flag <= seed[7:0];
			apb(1'b1, ADDR_PER_EN, 32'(seed[15:8]), 33'h0);
			apb(1'b1, ADDR_DMA_RT, 32'(seed[23:16]), 33'h0);
			apb(1'b1, ADDR_DTE_RT, 32'(seed[31:24]), 33'h0);
			@(posedge pclk);
			cmp("dma_act", 33'(seed[7:0] & seed[15:8] & seed[23:16]), 33'(dma_act));
			cmp("dte_act", 33'(seed[7:0] & seed[15:8] & seed[31:24]), 33'(dte_act));
			apb(1'b0, ADDR_PER_FLAG, 32'h0, 33'(seed[7:0]));
		end
		per_flag <= 8'h0a;
		apb(1'b1, ADDR_IRQ_EN, 32'h0, 33'h0);
		apb(1'b1, ADDR_PRI_PER, 32'hc18, 33'h0);
		apb(1'b1, ADDR_PER_EN, 32'hff, 33'h0);
		@(posedge pclk);
		cmp("cpu_req", 33'({1'b1, 4'd11, 3'd6}), 33'(cpu_req));
		apb(1'b1, ADDR_PRI_EXT, 32'h7, 33'h0);
		apb(1'b1, ADDR_IRQ_EN, 32'h1, 33'h0);
		u_ext.drive(0, 1'b0, 0);
		repeat (6) @(posedge pclk);
		cmp("cpu_req", 33'({1'b1, 4'd0, 3'd7}), 33'(cpu_req));
		repeat (4) @(posedge pclk);
		conclude();
	end
endmodule : interrupt_source_front_end_tb
